// ### hw/sip_pkg.sv
// ==========================================================================
// Shared constants for the soft interrupt pending register
package sip_pkg;

  // ========================================================================
  // Ancillary state register numbers
  localparam logic [4:0] SIP_ASR_SET = 5'h14;
  localparam logic [4:0] SIP_ASR_CLR = 5'h15;
  localparam logic [4:0] SIP_ASR_PEND = 5'h16;

  // ========================================================================
  // Field layout of the pending register
  localparam int SIP_PEND_W = 17;
  localparam int SIP_BIT_TM = 0;
  localparam int SIP_BIT_L14 = 14;
  localparam int SIP_BIT_L15 = 15;
  localparam int SIP_BIT_SM = 16;
  localparam int SIP_LVL_LO = 1;
  localparam int SIP_LVL_HI = 15;

  // ========================================================================
  // Reset values
  localparam logic [16:0] SIP_PEND_RST = 17'h0_0000;
  localparam logic [3:0] SIP_LVL_NONE = 4'h0;

endpackage : sip_pkg

// ### hw/sip_soft_interrupt_pending_reg.sv
// ==========================================================================
// Operation
// R1: Privileged access to register 22, else exception
// R2: Plain read returns, plain write replaces register
// R3: System tick match sets bit 16, level 14
// R4: Tick match sets bit 0, level 14
// R5: Software may set both match bits directly
// R6: Pending bit n raises level-n request
// R7: Level 14 from either match bit or bit 14
// R8: Level 15 from bit 15 or other source
// R9: Trap only if level above PROCESSOR_INTERRUPT_LEVEL, enabled, nonhyper
// R10: Match bits and bit 14 stay independent
// R11: Register 20 write ORs data bits 16:0
// R12: Register 21 write clears bits where data one
// R13: Set port write-only, privileged, no storage
// R14: Clear port write-only, privileged, no storage
// R15: Software prefers set/clear ports over read-modify-write
// R16: Level 14 handler inspects three source bits
// R17: Reserved bits read zero; reset clears pending
// R18: Hardware match set beats simultaneous clear
`timescale 1ns/1ps

module sip_soft_interrupt_pending_reg
  import sip_pkg::*;
#(
  parameter int DATA_W = 64
) (
  input wire logic i_clk_sys, // 250 MHz processor clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_asr_rd, // Ancillary read strobe
  input wire logic i_asr_wr, // Ancillary write strobe
  input wire logic [4:0] i_asr_num, // Ancillary register number
  input wire logic [DATA_W-1:0] i_asr_wdata, // Write data
  input wire logic i_priv, // Privileged mode
  input wire logic i_tick_dis, // Tick compare disable
  input wire logic i_tick_eq, // Tick compare equals counter
  input wire logic i_stick_dis, // System tick compare disable
  input wire logic i_stick_eq, // System tick compare equals counter
  input wire logic [3:0] i_pil, // Processor interrupt level
  input wire logic i_ie, // Global interrupt enable
  input wire logic i_hpriv, // Hypervisor mode flag
  input wire logic i_ext_l15, // Other level 15 source
  output logic [DATA_W-1:0] o_rdata, // Read data
  output logic o_rd_valid, // Read data valid pulse
  output logic o_priv_exc, // Privileged opcode exception pulse
  output logic o_ill_exc, // Illegal instruction pulse
  output logic [15:1] o_lvl_req, // Per-level interrupt requests
  output logic o_trap_req, // Trap request to trap logic
  output logic [3:0] o_trap_lvl // Level of the trap request
);

  // ========================================================================
  // Elaboration check
  if (DATA_W < SIP_PEND_W) begin : g_bad_width
    $error("DATA_W too narrow for the pending register");
  end

  // ========================================================================
  // Functions
  function automatic logic [15:1] level_map(input logic [16:0] pend,
                                            input logic ext15);
    logic [15:1] req;
    req = pend[15:1];
    req[SIP_BIT_L14] = pend[SIP_BIT_L14] | pend[SIP_BIT_TM] // R7
                       | pend[SIP_BIT_SM];
    req[SIP_BIT_L15] = pend[SIP_BIT_L15] | ext15; // R8
    return req;
  endfunction : level_map

  // Highest requested level strictly above the current level
  function automatic logic [3:0] top_level(input logic [15:1] req,
                                           input logic [3:0] processor_interrupt_level);
    logic [3:0] lvl;
    lvl = SIP_LVL_NONE;
    for (int n = SIP_LVL_LO; n <= SIP_LVL_HI; n++) begin
      if (req[n] && (4'(n) > processor_interrupt_level)) begin
        lvl = 4'(n);
      end
    end
    return lvl;
  endfunction : top_level

  // ========================================================================
  // Access decode
  logic [16:0] pend_r;
  logic [16:0] pend_nxt;
  logic [16:0] wbits;
  logic [16:0] hw_set;
  logic hit_set;
  logic hit_clr;
  logic hit_pend;
  logic acc_ours;
  logic wr_ok;
  logic set_wr;
  logic clr_wr;
  logic full_wr;
  logic rd_ok;
  logic rd_wo;
  logic tm_hit;
  logic sm_hit;
  logic [15:1] req_nxt;
  logic [3:0] lvl_nxt;
  logic trap_ok;

  // Upper write data bits never reach the register
  assign wbits = i_asr_wdata[16:0]; // R11 R12 R17
  assign hit_set = (i_asr_num == SIP_ASR_SET);
  assign hit_clr = (i_asr_num == SIP_ASR_CLR);
  assign hit_pend = (i_asr_num == SIP_ASR_PEND);
  assign acc_ours = (i_asr_rd | i_asr_wr) & (hit_set | hit_clr | hit_pend);
  assign wr_ok = i_asr_wr & i_priv; // R1
  assign set_wr = wr_ok & hit_set; // R13
  assign clr_wr = wr_ok & hit_clr; // R14
  assign full_wr = wr_ok & hit_pend; // R2
  assign rd_ok = i_asr_rd & i_priv & hit_pend; // R2
  // The ports have no state to return, so reading them is not an opcode
  assign rd_wo = i_asr_rd & i_priv & (hit_set | hit_clr); // R13 R14

  // ========================================================================
  // Timer match events
  assign tm_hit = ~i_tick_dis & i_tick_eq; // R4
  assign sm_hit = ~i_stick_dis & i_stick_eq; // R3
  assign hw_set = {sm_hit, 15'h0000, tm_hit}; // R10

  // ========================================================================
  // Next pending value; hardware set applied last so it always wins
  always_comb begin
    pend_nxt = pend_r;
    if (full_wr) begin
      pend_nxt = wbits; // R2 R5
    end else if (set_wr) begin
      pend_nxt = pend_r | wbits; // R11 R5
    end else if (clr_wr) begin
      pend_nxt = pend_r & ~wbits; // R12
    end
    pend_nxt = pend_nxt | hw_set; // R18 R3 R4
  end

  // ========================================================================
  // Request and trap selection, registered so outputs track pend_r
  assign req_nxt = level_map(pend_nxt, i_ext_l15); // R6
  assign lvl_nxt = top_level(req_nxt, i_pil); // R9
  assign trap_ok = i_ie & ~i_hpriv & (lvl_nxt != SIP_LVL_NONE); // R9

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_r <= SIP_PEND_RST; // R17
      o_lvl_req <= '0;
      o_trap_req <= 1'b0;
      o_trap_lvl <= SIP_LVL_NONE;
    end else begin
      pend_r <= pend_nxt;
      o_lvl_req <= req_nxt;
      o_trap_req <= trap_ok;
      o_trap_lvl <= trap_ok ? lvl_nxt : SIP_LVL_NONE;
    end
  end

  // ========================================================================
  // Read answer and exceptions
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
      o_rd_valid <= 1'b0;
      o_priv_exc <= 1'b0;
      o_ill_exc <= 1'b0;
    end else begin
      o_rdata <= rd_ok ? DATA_W'(pend_r) : '0; // R17
      o_rd_valid <= rd_ok;
      o_priv_exc <= acc_ours & ~i_priv; // R1 R13 R14
      o_ill_exc <= rd_wo;
    end
  end

  // ========================================================================
  // Assertions
  a_set_port_or: assert property ( // R11
    @(posedge i_clk_sys) disable iff (!i_rstn)
    set_wr |=> ((pend_r & $past(wbits)) == $past(wbits))
  ) else $error("set port did not set every selected bit");

  a_set_keeps: assert property ( // R10
    @(posedge i_clk_sys) disable iff (!i_rstn)
    set_wr |=> ((pend_r & $past(pend_r)) == $past(pend_r))
  ) else $error("set port cleared a bit");

  a_clr_port_and: assert property ( // R12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (clr_wr && !tm_hit && !sm_hit)
      |=> ((pend_r & $past(wbits)) == 17'h0_0000)
  ) else $error("clear port left a selected bit set");

  a_clr_match_wins: assert property ( // R18
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (clr_wr && tm_hit) |=> pend_r[SIP_BIT_TM]
  ) else $error("tick match lost against a clear");

  a_full_write: assert property ( // R2
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (full_wr && !tm_hit && !sm_hit) |=> (pend_r == $past(wbits))
  ) else $error("plain write did not replace the register");

  a_nonpriv_trap: assert property ( // R1
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (acc_ours && !i_priv) |=> (o_priv_exc && !o_rd_valid)
  ) else $error("unprivileged access not refused");

  a_nonpriv_hold: assert property ( // R13
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_asr_wr && !i_priv && !tm_hit && !sm_hit) |=> $stable(pend_r)
  ) else $error("unprivileged write changed the register");

  a_tick_match: assert property ( // R4
    @(posedge i_clk_sys) disable iff (!i_rstn)
    tm_hit |=> (pend_r[SIP_BIT_TM] && o_lvl_req[SIP_BIT_L14])
  ) else $error("tick match did not post level 14");

  a_stick_match: assert property ( // R3
    @(posedge i_clk_sys) disable iff (!i_rstn)
    sm_hit |=> (pend_r[SIP_BIT_SM] && o_lvl_req[SIP_BIT_L14])
  ) else $error("system tick match did not post level 14");

  a_level_map: assert property ( // R6
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_lvl_req[13:1] == pend_r[13:1]
  ) else $error("level requests differ from pending bits");

  a_lvl14_src: assert property ( // R7
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_lvl_req[SIP_BIT_L14] == (pend_r[SIP_BIT_TM] | pend_r[SIP_BIT_SM]
                               | pend_r[SIP_BIT_L14])
  ) else $error("level 14 request has a wrong source");

  a_lvl15_src: assert property ( // R8
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_lvl_req[SIP_BIT_L15] == (pend_r[SIP_BIT_L15] | $past(i_ext_l15))
  ) else $error("level 15 request has a wrong source");

  a_trap_gate: assert property ( // R9
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_trap_req |-> ($past(i_ie) && !$past(i_hpriv)
                    && (o_trap_lvl > $past(i_pil))
                    && o_lvl_req[o_trap_lvl])
  ) else $error("trap raised without its conditions");

  a_read_data: assert property ( // R17
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rd_ok |=> (o_rd_valid && (o_rdata == DATA_W'($past(pend_r))))
  ) else $error("read data wrong or reserved bits nonzero");

  a_port_noread: assert property ( // R14
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rd_wo |=> (o_ill_exc && !o_rd_valid)
  ) else $error("write-only port answered a read");

  // ========================================================================
  // Gating, cause and masking checks; the trap and exception pulses must
  // never appear without the request that explains them
  a_trap_withheld: assert property ( // R9
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (!$past(i_ie) || $past(i_hpriv)) |-> !o_trap_req
  ) else $error("trap raised while disabled or in hypervisor mode");

  a_trap_top: assert property ( // R9
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_trap_req |-> (({o_lvl_req, 1'b0} >> o_trap_lvl) == 16'h0001)
  ) else $error("trap level is not the highest request");

  a_reserved_zero: assert property ( // R17
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_rdata[DATA_W-1:SIP_PEND_W] == '0
  ) else $error("reserved read bits not zero");

  a_clr_keeps: assert property ( // R12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    clr_wr |=> ((pend_r & $past(pend_r) & ~$past(wbits))
                == ($past(pend_r) & ~$past(wbits)))
  ) else $error("clear port cleared an unselected bit");

  a_rd_idle: assert property ( // R2
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !rd_ok |=> (!o_rd_valid && (o_rdata == '0))
  ) else $error("read answer without a read");

  a_ill_cause: assert property ( // R13
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_ill_exc |-> $past(rd_wo)
  ) else $error("illegal pulse without a port read");

  a_priv_cause: assert property ( // R1
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_priv_exc |-> $past(acc_ours && !i_priv)
  ) else $error("privilege pulse without an unprivileged access");

  a_rd_priv: assert property ( // R1
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_rd_valid |-> $past(i_priv)
  ) else $error("read answered in unprivileged mode");

  a_sm_direct: assert property ( // R5
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (set_wr && wbits[SIP_BIT_SM]) |=> pend_r[SIP_BIT_SM]
  ) else $error("software could not set the system tick match bit");

  a_full_match_wins: assert property ( // R18
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (full_wr && tm_hit) |=> pend_r[SIP_BIT_TM]
  ) else $error("tick match lost against a plain write");

endmodule : sip_soft_interrupt_pending_reg

// ### dv/sip_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  bad_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
  end end

module testbench;
  import sip_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, priv = 1'b0;
  logic t_dis = 1'b0, t_eq = 1'b0, s_dis = 1'b0, s_eq = 1'b0;
  logic ie = 1'b0, hpriv = 1'b0, ext = 1'b0;
  logic [3:0] processor_interrupt_level = 4'h0;
  logic [4:0] num = 5'h00;
  logic [63:0] wdata = 64'h0, rdata;
  logic rd_valid, priv_exc, ill_exc, trap_req;
  logic [15:1] lvl_req;
  logic [3:0] trap_lvl;
  logic [16:0] pend = 17'h0_0000;
  logic [31:0] rnd = 32'hD8F647C1;
  int bad_count = 0, checks = 0;

  sip_soft_interrupt_pending_reg u_sip_soft_interrupt_pending_reg (
    .i_clk_sys(clk), .i_rstn(rstn), .i_asr_rd(rd), .i_asr_wr(wr),
    .i_asr_num(num), .i_asr_wdata(wdata), .i_priv(priv),
    .i_tick_dis(t_dis), .i_tick_eq(t_eq), .i_stick_dis(s_dis),
    .i_stick_eq(s_eq), .i_pil(processor_interrupt_level), .i_ie(ie), .i_hpriv(hpriv),
    .i_ext_l15(ext), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_priv_exc(priv_exc), .o_ill_exc(ill_exc), .o_lvl_req(lvl_req),
    .o_trap_req(trap_req), .o_trap_lvl(trap_lvl));

  initial begin
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // ========================================================================
  // Reference model: one edge of the register and its requests
  task automatic step;
    logic [16:0] nx;
    logic [15:1] lv;
    logic [3:0] tl;
    logic take;
    @(posedge clk);
    #1;
    nx = pend;
    take = wr && priv;
    if (take && num == SIP_ASR_PEND) nx = wdata[16:0];
    if (take && num == SIP_ASR_SET) nx = nx | wdata[16:0];
    if (take && num == SIP_ASR_CLR) nx = nx & ~wdata[16:0];
    if (t_eq && !t_dis) nx[SIP_BIT_TM] = 1'b1;
    if (s_eq && !s_dis) nx[SIP_BIT_SM] = 1'b1;
    lv = nx[15:1];
    lv[15] = nx[15] | ext;
    lv[14] = nx[14] | nx[SIP_BIT_TM] | nx[SIP_BIT_SM];
    tl = 4'h0;
    for (int n = 1; n <= 15; n++) if (lv[n] && n > int'(processor_interrupt_level)) tl = 4'(n);
    `CHK("rd_valid", rd && priv && num == SIP_ASR_PEND, rd_valid)
    `CHK("rdata", rd_valid ? {47'h0, pend} : 64'h0, rdata)
    `CHK("priv_exc", (rd || wr) && !priv && num >= SIP_ASR_SET
         && num <= SIP_ASR_PEND, priv_exc)
    `CHK("ill_exc", rd && priv && (num == SIP_ASR_SET || num == SIP_ASR_CLR), ill_exc)
    `CHK("lvl_req", lv, lvl_req)
    `CHK("trap_req", tl != 4'h0 && ie && !hpriv, trap_req)
    `CHK("trap_lvl", (ie && !hpriv) ? tl : 4'h0, trap_lvl)
    pend = nx;
  endtask : step

  task automatic drive(input logic r, w, input logic [4:0] n,
                       input logic [63:0] d, input logic p, t);
    {rd, wr, num, wdata, priv, t_eq, t_dis} = {r, w, n, d, p, t, 1'b0};
    {s_eq, s_dis, processor_interrupt_level, ie, hpriv, ext} = {1'b0, 1'b0, 4'h0, 1'b1, 2'b0};
    step();
  endtask : drive

  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #80000;
    bad_count++;
    complete_run();
  end

  // ========================================================================
  // Corner cases, then random traffic
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    `CHK("lvl_req rst", 15'h0000, lvl_req)
    drive(1, 1, SIP_ASR_PEND, 64'hFFFF_FFFF_FFFF_FFFF, 1, 0);
    drive(1, 1, SIP_ASR_CLR, 64'hFFFF_FFFF_FFFF_FFFF, 1, 1);
    drive(1, 1, SIP_ASR_SET, 64'hFFFF_FFFF_FFFE_0000, 1, 0);
    drive(1, 1, SIP_ASR_SET, 64'h0000_0000_0000_4000, 0, 0);
    drive(1, 1, SIP_ASR_SET, 64'h0000_0000_0001_0001, 1, 0);
    drive(1, 1, SIP_ASR_CLR, 64'h0000_0000_0000_0001, 1, 0);
    drive(0, 1, SIP_ASR_SET, 64'h0000_0000_0001_4001, 1, 0);
    drive(1, 0, SIP_ASR_PEND, 64'h0, 1, 0);
    drive(1, 1, SIP_ASR_PEND, 64'h0000_0000_0000_8000, 0, 0);
    drive(1, 0, SIP_ASR_CLR, 64'h0, 1, 0);
    for (int i = 0; i < 2000; i++) begin
      rnd = lfsr(rnd);
      {rd, wr} = rnd[1:0];
      case (rnd[3:2])
        2'd0: num = SIP_ASR_SET;
        2'd1: num = SIP_ASR_CLR;
        2'd2: num = SIP_ASR_PEND;
        default: num = rnd[8:4];
      endcase
      priv = rnd[9] | rnd[10] | rnd[11];
      wdata = {rnd, lfsr(rnd)};
      {t_eq, t_dis} = {rnd[12] & rnd[13], rnd[14] & rnd[15]};
      {s_eq, s_dis} = {rnd[16] & rnd[17], rnd[18] & rnd[19]};
      processor_interrupt_level = rnd[23:20];
      {ie, hpriv} = {rnd[24] | rnd[25], rnd[26] & rnd[27]};
      ext = rnd[28] & rnd[29] & rnd[30];
      step();
    end
    complete_run();
  end
endmodule : testbench
